// File: rtl/maint_pkg.sv
// shared constants and types for the supervisory and maintenance controls
package maint_pkg;

    // scan-control literal values
    localparam logic [3:0] EMIT_LOAD_LINKAGE = 4'h8;
    localparam logic [3:0] EMIT_SET_PASS_FAIL = 4'h1;
    localparam logic [3:0] EMIT_CLEAR_PASS_FAIL = 4'h5;

    // storage data register bit positions, bit 0 is the most significant
    localparam int SDR_SEQ_MSB = 0;
    localparam int SDR_SEQ_LSB = 2;
    localparam int SDR_BIT_OVERRIDE = 4;
    localparam int SDR_BIT_SCAN_ADV = 5;
    localparam int SDR_BIT_SEQ_STAT = 6;

    // fault-test operation codes
    localparam logic [7:0] FLT_OP_CLEAR_A = 8'h07;
    localparam logic [7:0] FLT_OP_CLEAR_B = 8'h08;
    localparam logic [7:0] FLT_OP_TEST = 8'h0E;
    localparam logic [7:0] FLT_OP_STEP = 8'h0F;

    // sequence counter and test repeat counter
    localparam logic [2:0] SEQ_LAST = 3'h7;
    localparam int TEST_REPEATS = 16;
    localparam int REPEAT_W = $clog2(TEST_REPEATS);
    localparam logic [REPEAT_W-1:0] REPEAT_RESET = 4'h1;

    // logout save locations
    localparam logic [7:0] LOG_ADDR_SDR = 8'h80;
    localparam logic [7:0] LOG_ADDR_SAR = 8'h84;
    localparam logic [7:0] LOG_ADDR_IAR = 8'h88;
    localparam logic [7:0] LOG_ADDR_STEP = 8'h04;
    localparam logic [1:0] LOG_WORDS_LAST = 2'h2;

    // cpu control mode, one-hot
    typedef enum logic [2:0] {
        MODE_SEQ = 3'b001,
        MODE_MS  = 3'b010,
        MODE_CS  = 3'b100
    } mode_t;

    localparam mode_t MODE_RESET = MODE_CS;

endpackage

// File: rtl/pin_filter.sv
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/100ps
module pin_filter #(
    parameter int W = 3
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // the level moves only once stages two and three agree
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end else if (i_ce) begin
                    s1_q <= i_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign o_level[g] = lvl_q;
        end
    endgenerate
endmodule

// File: rtl/supervisory_ctl.sv
// supervisory clock stop, control mode and maintenance stat logic
// Functional notes
// - error with log request, or pushbutton, starts logout
// - sequencing stat inhibits storage unless override on
// - scan-control 1000 loads sequencing stat from bit 6
// - sequence counter seven clears sequencing stat
// - scan-control 1000 loads override stat from bit 4
// - count seven with sequencing on clears override
// - scan advance loaded from data bit 5
// - start with force-pass sets scan advance
// - testing scan advance clears it unless inhibited
// - scan advance off after reset and during logout
// - main store mode binary trigger clear, step, test
// - repeat counter branches, increments, resets to one
// - scan-control 0001 sets fail or pass by binary
// - scan-control 0101 clears pass and fail
// - branch orders test pass or fail trigger
// - free-running clocks are never gated here
// - four stop triggers; holdoff also raises the cpu/io stop, so the channel stops too
// - control-store and main-storage stops gate their loads
// - fault-test load request raises normal interrupt
// - mode change: stop, dead cycle, release needed clocks
// - logout dead cycle sets log, sequencing mode; saves three
// - main store call; release control store after save
// - control-store call then clear all stops
// - clock interrupt sets stops, leaves mode alone
`timescale 1ns/100ps
module supervisory_ctl (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    input  wire logic                          i_error_check,
    input  wire logic                          i_log_request,
    input  wire logic                          i_logout_pushbutton,
    input  wire logic                          i_start_pushbutton,
    input  wire logic                          i_force_pass_sw,
    input  wire logic                          i_scan_control_order,
    input  wire logic [3:0]                    i_emit,
    input  wire logic [0:31]                   i_storage_data_reg,
    input  wire logic                          i_seq_step,
    input  wire logic                          i_scan_advance_test,
    input  wire logic                          i_fault_locate_test_valid,
    input  wire logic [7:0]                    i_fault_locate_test_op,
    input  wire logic                          i_counter_zero_order,
    input  wire logic                          i_branch_on_pass,
    input  wire logic                          i_branch_on_fail,
    input  wire logic                          i_flt_load_req,
    input  wire logic                          i_mode_change_req,
    input  wire maint_pkg::mode_t              i_new_mode,
    input  wire logic                          i_storage_holdoff,
    input  wire logic                          i_single_cycle,
    input  wire logic                          i_cs_saved,
    input  wire logic                          i_log_reset,
    output logic                               o_log_trigger,
    output logic                               o_seq_stat,
    output logic                               o_storage_override_stat,
    output logic                               o_inhibit_storage,
    output logic                               o_scan_advance_stat,
    output logic [2:0]                         o_seq_count,
    output logic                               o_binary_trigger,
    output logic [maint_pkg::REPEAT_W-1:0]     o_test_repeat_counter,
    output logic                               o_pass_trigger,
    output logic                               o_fail_trigger,
    output logic                               o_branch_valid,
    output logic                               o_branch_taken,
    output maint_pkg::mode_t                   o_mode,
    output logic                               o_stop_cpu_io,
    output logic                               o_stop_cs,
    output logic                               o_stop_ms,
    output logic                               o_stop_holdoff,
    output logic                               o_cpu_clk_en,
    output logic                               o_channel_clk_en,
    output logic                               o_cs_clk_en,
    output logic                               o_ms_clk_en,
    output logic                               o_gate_status,
    output logic                               o_store_strobe,
    output logic [7:0]                         o_store_addr
);
    import maint_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'b000001,
        ST_DEAD      = 6'b000010,
        ST_LOG_STORE = 6'b000100,
        ST_MS_WAIT   = 6'b001000,
        ST_CS_CALL   = 6'b010000,
        ST_RELEASE   = 6'b100000
    } state_t;

    state_t                st_q;
    state_t                st_d;
    mode_t                 mode_q;
    mode_t                 target_q;
    logic [2:0]            pins;
    logic                  logout_pb;
    logic                  start_pb;
    logic                  force_pass;
    logic                  logout_pb_q;
    logic                  start_pb_q;
    logic                  log_q;
    logic                  logout_act_q;
    logic                  seq_q;
    logic                  ovr_q;
    logic                  pss_q;
    logic [2:0]            seq_cnt_q;
    logic                  bin_q;
    logic [REPEAT_W-1:0]   rep_q;
    logic                  pass_q;
    logic                  fail_q;
    logic                  brv_q;
    logic                  brt_q;
    logic                  stop_cpu_q;
    logic                  stop_cs_q;
    logic                  stop_ms_q;
    logic                  stop_hold_q;
    logic                  clk_hold_q;
    logic [1:0]            word_q;
    logic [7:0]            addr_q;

    pin_filter #(.W(3)) u_pins (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_pin     ({i_logout_pushbutton, i_start_pushbutton, i_force_pass_sw}),
        .o_level   (pins)
    );
    assign logout_pb  = pins[2];
    assign start_pb   = pins[1];
    assign force_pass = pins[0];

    // decodes
    wire idle       = (st_q == ST_IDLE);
    wire load_lk    = i_scan_control_order && (i_emit == EMIT_LOAD_LINKAGE);
    wire pf_set     = i_scan_control_order && (i_emit == EMIT_SET_PASS_FAIL);
    wire pf_clr     = i_scan_control_order && (i_emit == EMIT_CLEAR_PASS_FAIL);
    wire logout_rq  = (i_error_check && i_log_request) || (logout_pb && !logout_pb_q);
    wire logout_go  = idle && logout_rq;
    wire normal_rq  = (i_flt_load_req && !start_pb && (mode_q != MODE_SEQ))
                      || i_mode_change_req;
    wire normal_go  = idle && !logout_rq && normal_rq;
    wire clock_int  = i_storage_holdoff || i_single_cycle;
    wire clock_rel  = idle && clk_hold_q && !clock_int;
    wire seq_end    = seq_q && (seq_cnt_q == SEQ_LAST);
    wire inhibit    = seq_q && !ovr_q;
    wire ms_mode    = (mode_q == MODE_MS);
    wire flt_op     = i_fault_locate_test_valid && ms_mode;
    wire bin_clr    = flt_op && (i_fault_locate_test_op == FLT_OP_CLEAR_A
                                 || i_fault_locate_test_op == FLT_OP_CLEAR_B);
    wire bin_step   = flt_op && (i_fault_locate_test_op == FLT_OP_STEP);
    wire bin_test   = flt_op && (i_fault_locate_test_op == FLT_OP_TEST);
    // cleared on the go edge so the dead cycle already shows it off
    wire pss_hold   = log_q || logout_act_q || logout_go;
    wire pss_force  = start_pb && !start_pb_q && force_pass;
    wire stop_set   = logout_go || normal_go || clock_int;
    wire release_all = (st_q == ST_RELEASE) || clock_rel;
    wire any_test   = i_scan_advance_test || bin_test || i_counter_zero_order
                      || i_branch_on_pass || i_branch_on_fail;
    wire test_res   = i_scan_advance_test   ? pss_q :
                      bin_test              ? bin_q :
                      i_counter_zero_order  ? (rep_q == '0) :
                      i_branch_on_pass      ? pass_q : fail_q;

    // sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (logout_go || normal_go) begin
                    st_d = ST_DEAD;
                end
            end
            ST_DEAD: begin
                st_d = logout_act_q ? ST_LOG_STORE : ST_RELEASE;
            end
            ST_LOG_STORE: begin
                if (word_q == LOG_WORDS_LAST) begin
                    st_d = ST_MS_WAIT;
                end
            end
            ST_MS_WAIT: begin
                if (i_cs_saved) begin
                    st_d = ST_CS_CALL;
                end
            end
            ST_CS_CALL: begin
                st_d = ST_RELEASE;
            end
            ST_RELEASE: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q         <= ST_IDLE;
            logout_act_q <= 1'b0;
            target_q     <= MODE_RESET;
            word_q       <= 2'h0;
            addr_q       <= LOG_ADDR_SDR;
            logout_pb_q  <= 1'b0;
            start_pb_q   <= 1'b0;
        end else if (i_ce) begin
            st_q        <= st_d;
            logout_pb_q <= logout_pb;
            start_pb_q  <= start_pb;
            if (logout_go) begin
                logout_act_q <= 1'b1;
            end else if (st_q == ST_RELEASE) begin
                logout_act_q <= 1'b0;
            end
            if (normal_go) begin
                target_q <= (i_mode_change_req ? i_new_mode : MODE_SEQ);
            end
            // three saves in a row: data, address, instruction address
            if (st_q == ST_LOG_STORE) begin
                word_q <= word_q + 2'h1;
                addr_q <= addr_q + LOG_ADDR_STEP;
            end else begin
                word_q <= 2'h0;
                addr_q <= LOG_ADDR_SDR;
            end
        end
    end

    // control mode moved only in the dead cycle or by calls; log trigger set in the dead cycle, cleared by log reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= MODE_RESET;
            log_q  <= 1'b0;
        end else if (i_ce) begin
            if (st_q == ST_DEAD) begin
                mode_q <= logout_act_q ? MODE_SEQ : target_q;
            end else if (st_q == ST_LOG_STORE && word_q == LOG_WORDS_LAST) begin
                mode_q <= MODE_MS;
            end else if (st_q == ST_CS_CALL) begin
                mode_q <= MODE_CS;
            end
            if (st_q == ST_DEAD && logout_act_q) begin
                log_q <= 1'b1;
            end else if (i_log_reset) begin
                log_q <= 1'b0;
            end
        end
    end

    // clock stop triggers; a set always beats a release in the same cycle
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            stop_cpu_q  <= 1'b0;
            stop_cs_q   <= 1'b0;
            stop_ms_q   <= 1'b0;
            stop_hold_q <= 1'b0;
            clk_hold_q  <= 1'b0;
        end else if (i_ce) begin
            if (stop_set) begin
                stop_cpu_q <= 1'b1;
                stop_cs_q  <= 1'b1;
                stop_ms_q  <= 1'b1;
            end else begin
                if (release_all) begin
                    stop_cpu_q <= 1'b0;
                end
                if (release_all || (st_q == ST_MS_WAIT && i_cs_saved)) begin
                    stop_cs_q <= 1'b0;
                end
                if (release_all || (st_q == ST_DEAD && logout_act_q)) begin
                    stop_ms_q <= 1'b0;
                end
            end
            stop_hold_q <= i_storage_holdoff;
            if (idle && clock_int) begin
                clk_hold_q <= 1'b1;
            end else if (clock_rel || !idle) begin
                clk_hold_q <= 1'b0;
            end
        end
    end

    // maintenance stats and sequence counter
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            seq_q     <= 1'b0;
            ovr_q     <= 1'b0;
            pss_q     <= 1'b0;
            seq_cnt_q <= 3'h0;
        end else if (i_ce) begin
            if (load_lk) begin
                seq_q     <= i_storage_data_reg[SDR_BIT_SEQ_STAT];
                ovr_q     <= i_storage_data_reg[SDR_BIT_OVERRIDE];
                seq_cnt_q <= i_storage_data_reg[SDR_SEQ_MSB:SDR_SEQ_LSB];
            end else begin
                if (seq_end) begin
                    seq_q <= 1'b0;
                    ovr_q <= 1'b0;
                end else if (seq_q && i_seq_step) begin
                    seq_cnt_q <= seq_cnt_q + 3'h1;
                end
            end
            if (pss_hold) begin
                pss_q <= 1'b0;
            end else if (load_lk) begin
                pss_q <= i_storage_data_reg[SDR_BIT_SCAN_ADV];
            end else if (pss_force) begin
                pss_q <= 1'b1;
            end else if (i_scan_advance_test && !inhibit) begin
                pss_q <= 1'b0;
            end
        end
    end

    // fault-test triggers, repeat counter and branch result
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bin_q  <= 1'b0;
            rep_q  <= REPEAT_RESET;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            brv_q  <= 1'b0;
            brt_q  <= 1'b0;
        end else if (i_ce) begin
            if (bin_clr) begin
                bin_q <= 1'b0;
            end else if (bin_step) begin
                bin_q <= !bin_q;
            end
            if (i_counter_zero_order) begin
                rep_q <= rep_q + 1'b1;
            end
            // a set in the same cycle as the clear order wins
            if (pf_set) begin
                fail_q <= bin_q ? 1'b1 : fail_q && !pf_clr;
                pass_q <= bin_q ? pass_q && !pf_clr : 1'b1;
            end else if (pf_clr) begin
                fail_q <= 1'b0;
                pass_q <= 1'b0;
            end
            brv_q <= any_test;
            brt_q <= any_test && test_res;
        end
    end

    // only the gated clocks appear here; free-running ones bypass this block
    assign o_cpu_clk_en     = !stop_cpu_q && !stop_hold_q;
    assign o_channel_clk_en = !stop_cpu_q;
    assign o_cs_clk_en      = !stop_cs_q;
    assign o_ms_clk_en      = !stop_ms_q;

    assign o_log_trigger           = log_q;
    assign o_seq_stat              = seq_q;
    assign o_storage_override_stat = ovr_q;
    assign o_inhibit_storage       = inhibit;
    assign o_scan_advance_stat     = pss_q;
    assign o_seq_count             = seq_cnt_q;
    assign o_binary_trigger        = bin_q;
    assign o_test_repeat_counter   = rep_q;
    assign o_pass_trigger          = pass_q;
    assign o_fail_trigger          = fail_q;
    assign o_branch_valid          = brv_q;
    assign o_branch_taken          = brt_q;
    assign o_mode                  = mode_q;
    assign o_stop_cpu_io           = stop_cpu_q;
    assign o_stop_cs               = stop_cs_q;
    assign o_stop_ms               = stop_ms_q;
    assign o_stop_holdoff          = stop_hold_q;
    assign o_gate_status           = (st_q == ST_DEAD);
    assign o_store_strobe          = (st_q == ST_LOG_STORE);
    assign o_store_addr            = addr_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_saves;
        (o_store_strobe && o_store_addr == LOG_ADDR_SDR && i_ce) ##1
        (o_store_strobe && o_store_addr == LOG_ADDR_SAR && i_ce) ##1
        (o_store_strobe && o_store_addr == LOG_ADDR_IAR);
    endsequence
    sequence s_cs_call;
        (st_q == ST_CS_CALL && i_ce) ##1 (i_ce && !clock_int);
    endsequence

    a_mode_onehot: assert property ($onehot(mode_q))
        else $error("control mode not one-hot");
    a_seq_end_clear: assert property (i_ce && seq_end && !load_lk |=> !seq_q && !ovr_q)
        else $error("sequencing stat not cleared at seven");
    a_seq_load: assert property (i_ce && load_lk |=>
        seq_q == $past(i_storage_data_reg[SDR_BIT_SEQ_STAT]))
        else $error("sequencing stat not loaded");
    a_pss_logout: assert property (log_q |-> !pss_q)
        else $error("scan advance on during logout");
    a_pss_test: assert property (i_ce && i_scan_advance_test && !inhibit && !pss_hold
        && !load_lk && !pss_force |=> !pss_q)
        else $error("scan advance not cleared by test");
    a_pf_set: assert property (i_ce && pf_set |=> ($past(bin_q) ? fail_q : pass_q))
        else $error("pass or fail not set");
    a_pf_clear: assert property (i_ce && pf_clr && !pf_set |=> !pass_q && !fail_q)
        else $error("pass and fail not cleared");
    a_bin_step: assert property (i_ce && bin_step |=> bin_q != $past(bin_q))
        else $error("binary trigger did not toggle");
    a_normal_stop: assert property (i_ce && normal_go |=>
        stop_cpu_q && stop_cs_q && stop_ms_q && o_gate_status)
        else $error("normal interrupt did not stop clocks");
    a_clock_int: assert property (i_ce && clock_int && idle |=>
        stop_cpu_q && stop_cs_q && stop_ms_q && $stable(mode_q))
        else $error("clock interrupt misbehaved");
    a_logout_dead: assert property (i_ce && st_q == ST_DEAD && logout_act_q && !clock_int
        |=> (log_q && mode_q == MODE_SEQ && !stop_ms_q) and s_saves)
        else $error("logout dead cycle or saves wrong");
    a_cs_release: assert property (s_cs_call |=>
        mode_q == MODE_CS && !stop_cpu_q && !stop_cs_q && !stop_ms_q)
        else $error("control-store call did not release clocks");
endmodule

// File: verif/test_supervisory_ctl.sv
// self-checking bench for the supervisory and maintenance controls
`timescale 1ns/100ps
module test_supervisory_ctl;
    import maint_pkg::*;
    localparam int SCO = 0, STP = 1, SAT = 2, FAULT_LOCATE_TEST = 3, CZ = 4, BP = 5, BF = 6, LRS = 7;
    logic        clk = 0, rst = 1, err = 0, lreq = 0, lpb = 0, mreq = 0, hold = 0, saved = 0;
    logic        flr = 0, spb = 0, fps = 0;
    logic [7:0]  ord = '0, code = '0;
    logic [0:31] storage_data_reg = '0, seed = 32'h0000_003B;
    mode_t       nmode = MODE_MS, mode;
    int          bad_count = 0, comparisons = 0, cycles = 0, n;
    logic [7:0]  seen [$];
    wire         logt, seq, ovr, inh, sadv, bin, pass, fail, bv, bt, s_cpu, s_cs, s_ms, s_hold;
    wire         cpu_en, ch_en, cs_en, ms_en, gate, strobe;
    wire [2:0]   cnt;
    wire [3:0]   rc;
    wire [7:0]   saddr;
    supervisory_ctl supervisory_ctl_i (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1),
        .i_error_check(err), .i_log_request(lreq), .i_logout_pushbutton(lpb),
        .i_start_pushbutton(spb), .i_force_pass_sw(fps), .i_scan_control_order(ord[SCO]),
        .i_emit(code[3:0]), .i_storage_data_reg(storage_data_reg), .i_seq_step(ord[STP]),
        .i_scan_advance_test(ord[SAT]), .i_fault_locate_test_valid(ord[FAULT_LOCATE_TEST]),
        .i_fault_locate_test_op(code), .i_counter_zero_order(ord[CZ]), .i_branch_on_pass(ord[BP]),
        .i_branch_on_fail(ord[BF]), .i_flt_load_req(flr), .i_mode_change_req(mreq),
        .i_new_mode(nmode), .i_storage_holdoff(hold), .i_single_cycle(1'b0), .i_cs_saved(saved),
        .i_log_reset(ord[LRS]), .o_log_trigger(logt), .o_seq_stat(seq),
        .o_storage_override_stat(ovr), .o_inhibit_storage(inh), .o_scan_advance_stat(sadv),
        .o_seq_count(cnt), .o_binary_trigger(bin), .o_test_repeat_counter(rc),
        .o_pass_trigger(pass), .o_fail_trigger(fail), .o_branch_valid(bv), .o_branch_taken(bt),
        .o_mode(mode), .o_stop_cpu_io(s_cpu), .o_stop_cs(s_cs), .o_stop_ms(s_ms),
        .o_stop_holdoff(s_hold), .o_cpu_clk_en(cpu_en), .o_channel_clk_en(ch_en),
        .o_cs_clk_en(cs_en), .o_ms_clk_en(ms_en), .o_gate_status(gate),
        .o_store_strobe(strobe), .o_store_addr(saddr));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    function automatic logic [0:31] lfsr(input logic [0:31] s);
        return {s[1:31], s[0] ^ s[10] ^ s[30] ^ s[31]};
    endfunction
    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one microorder: raised after an edge, taken at the next, checked mid-cycle
    task automatic fire(input int b, input logic [7:0] c = '0, input logic [0:31] d = '0);
        @(posedge clk);
        ord[b] <= 1'b1;
        code <= c;
        storage_data_reg <= d;
        @(posedge clk);
        ord <= '0;
        @(negedge clk);
    endtask
    task automatic br(input logic exp);
        n = 0;
        while (bv !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        chk({bv, bt}, {1'b1, exp});
    endtask
    task automatic wait_mode(input mode_t m);
        n = 0;
        while (mode !== m && n < 30) begin
            @(negedge clk);
            n++;
        end
        chk(mode, m);
        repeat (2) @(negedge clk);
        chk({s_cpu, s_cs, s_ms, s_hold}, 4'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({mode, rc, sadv, s_cpu, s_cs, s_ms, s_hold}, {MODE_RESET, REPEAT_RESET, 5'h00});
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            fire(SCO, EMIT_LOAD_LINKAGE, seed);
            chk({seq, ovr, sadv, inh}, {seed[6], seed[4], seed[5], seed[6] & ~seed[4]});
        end
        fire(SCO, EMIT_LOAD_LINKAGE, 32'hAA00_0000);
        chk({cnt, seq, ovr}, 5'h17);
        fire(STP);
        fire(STP);
        @(negedge clk);
        chk({cnt, seq, ovr}, 5'h1C);
        fire(SCO, EMIT_LOAD_LINKAGE, 32'h0600_0000);
        fire(SAT);
        chk(sadv, 1'b1);
        fire(SCO, EMIT_LOAD_LINKAGE, 32'h0400_0000);
        fire(SAT);
        br(1'b1);
        chk(sadv, 1'b0);
        fire(SCO, EMIT_SET_PASS_FAIL);
        chk({pass, fail}, 2'h2);
        fire(BP);
        br(1'b1);
        fire(BF);
        br(1'b0);
        fire(SCO, EMIT_CLEAR_PASS_FAIL);
        chk({pass, fail}, 2'h0);
        fire(CZ);
        br(1'b0);
        chk(rc, 4'h2);
        repeat (14) fire(CZ);
        fire(CZ);
        br(1'b1);
        fire(FAULT_LOCATE_TEST, FLT_OP_STEP);
        chk(bin, 1'b0);
        @(posedge clk);
        hold <= 1'b1;
        repeat (3) @(negedge clk);
        chk({s_cpu, s_cs, s_ms, s_hold, cpu_en, ch_en, mode}, {6'h3C, MODE_CS});
        @(posedge clk);
        hold <= 1'b0;
        repeat (3) @(negedge clk);
        chk({s_cpu, s_cs, s_ms, s_hold, cpu_en, cs_en, ms_en}, 7'h07);
        @(posedge clk);
        mreq <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({s_cpu, s_cs, s_ms, gate}, 4'hF);
        @(posedge clk);
        mreq <= 1'b0;
        wait_mode(MODE_MS);
        fire(FAULT_LOCATE_TEST, FLT_OP_STEP);
        fire(FAULT_LOCATE_TEST, FLT_OP_TEST);
        br(1'b1);
        fire(SCO, EMIT_SET_PASS_FAIL);
        chk({pass, fail}, 2'h1);
        for (int j = 0; j < 2; j++) begin
            fire(FAULT_LOCATE_TEST, (j == 0) ? FLT_OP_CLEAR_A : FLT_OP_CLEAR_B);
            chk(bin, 1'b0);
            fire(FAULT_LOCATE_TEST, FLT_OP_STEP);
        end
        // fault-test load request drops the cpu into sequence counter mode
        @(posedge clk);
        flr <= 1'b1;
        wait_mode(MODE_SEQ);
        @(posedge clk);
        flr <= 1'b0;
        fps <= 1'b1;
        spb <= 1'b1;
        repeat (6) @(negedge clk);
        chk(sadv, 1'b1);
        // error path first, pushbutton press second; scan advance set to see it dropped
        for (int k = 0; k < 2; k++) begin
            fire(SCO, EMIT_LOAD_LINKAGE, 32'h0400_0000);
            @(posedge clk);
            err <= (k == 0);
            lpb <= (k == 1);
            lreq <= 1'b1;
            seen.delete();
            repeat (12) begin
                @(posedge clk);
                err <= 1'b0;
                @(negedge clk);
                if (gate === 1'b1)
                    chk(sadv, 1'b0);
                if (strobe === 1'b1) begin
                    seen.push_back(saddr);
                    chk({mode, s_ms, logt}, {MODE_SEQ, 2'h1});
                end
            end
            chk({seen[0], seen[1], seen[2]}, {LOG_ADDR_SDR, LOG_ADDR_SAR, LOG_ADDR_IAR});
            chk(mode, MODE_MS);
            @(posedge clk);
            saved <= 1'b1;
            lpb <= 1'b0;
            wait_mode(MODE_CS);
            @(posedge clk);
            saved <= 1'b0;
            lreq <= 1'b0;
            fire(LRS);
            chk(logt, 1'b0);
        end
        complete_run();
    end
endmodule
